// [src/swd_pkg.sv]
// swd_pkg: register map, field layout, reset values, timing constants
// assumes a 50 MHz clock and an Avalon-MM register bus with byte addresses
package swd_pkg;
   // ********************************
   // register byte offsets
   // ********************************
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_BITQ = 6'h04;
   localparam logic [5:0] REG_SPT  = 6'h08;
   localparam logic [5:0] REG_CSEL = 6'h0C;
   localparam logic [5:0] REG_ULIM = 6'h10;
   localparam logic [5:0] REG_LLIM = 6'h14;
   localparam logic [5:0] REG_FILT = 6'h18;
   localparam logic [5:0] REG_CNTH = 6'h1C;
   localparam logic [5:0] REG_CNTL = 6'h20;
   localparam logic [5:0] REG_TRIM = 6'h24;
   localparam logic [5:0] REG_OPT  = 6'h28;
   localparam logic [5:0] REG_STAT = 6'h2C;
   // ********************************
   // reset values and field positions
   // ********************************
   localparam logic [7:0] BITQ_RST = 8'h0A;
   localparam logic [5:0] SPT_RST  = 6'h33;
   localparam logic [1:0] CSEL_RST = 2'h0;
   localparam logic [7:0] ULIM_RST = 8'h0F;
   localparam logic [7:0] LLIM_RST = 8'h05;
   localparam logic [4:0] FILT_RST = 5'h05;
   localparam logic [7:0] TRIM_RST = 8'h80;
   localparam logic [7:0] OPT_RST  = 8'h00;
   localparam int         STAT_FLAG = 8;
   localparam int         STAT_QLSB = 16;
   localparam logic [1:0] UNLOCK   = 2'h3;
   // ********************************
   // frame and counter constants
   // ********************************
   localparam logic [5:0] ERR_OVF   = 6'h20;
   localparam logic [4:0] EDL_IDX   = 5'h0E;
   localparam logic [3:0] EOF_BITS  = 4'h7;
   localparam logic [3:0] IDLE_BITS = 4'h6;
   localparam logic [2:0] STUFF_RUN = 3'h5;
   localparam int         CLK_KHZ   = 50000;
   localparam int         IDLE_MS   = 600;
   localparam int         IDLE_CYC  = IDLE_MS * CLK_KHZ;
   // control word, top field first, measure enable lands in bit 0
   typedef struct packed {
      logic [1:0] trim_unlock;
      logic       wake_receiver_select;
      logic       clock_recovery_enable;
      logic       error_counter_freeze;
      logic       fd_tolerance_enable;
      logic       oscillator_measure_enable;
   } swd_ctrl_t;
   localparam swd_ctrl_t CTRL_RST = '0;
   // outcome of one frame
   typedef struct packed {
      logic ok;
      logic fd;
      logic err;
   } swd_evt_t;
   typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_CLASSIC, ST_SKIP} swd_state_t;
endpackage : swd_pkg

// [src/swd_decoder.sv]
// swd_decoder: selective-wake frame decoder configuration and run-time core
// assumes synchronous inputs, 50 MHz clk, Avalon-MM master on the bus side
// Contract
// - measure enable counts transmit pulse length
// - trim writes only when unlocked and measuring
// - FD tolerant: stop decoding FD frames
// - no stuff/CRC/form checks after EDL
// - no wake from FD frames
// - ready again after FD end-of-frame
// - EDL one is FD, zero classic
// - tolerance off: FD/bad up, good down
// - tolerance on, unfrozen: good frames down
// - tolerance and freeze: counter held zero
// - idle timeout clears counter freeze
// - recovery adjusts decode clock to stream
// - limit reached reloads bit quanta
// - receiver select picks decoder input
// - bit quanta sets quanta per bit
// - overflow wakes, flags, shows 100000
// - idle timeout 0.6 to 1.2 seconds
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module swd_decoder #(
   parameter int IDLE_CYCLES = swd_pkg::IDLE_CYC
) (
   // clock and reset
   input  wire  logic        clk,
   input  wire  logic        reset_n,
   // avalon-mm slave
   input  wire  logic [5:0]  avs_address,
   input  wire  logic        avs_read,
   input  wire  logic        avs_write,
   input  wire  logic [31:0] avs_writedata,
   output logic       [31:0] avs_readdata,
   output logic              avs_waitrequest,
   // bus receivers and transmit pin
   input  wire  logic        rx_normal,
   input  wire  logic        rx_wake,
   input  wire  logic        transmit_data_input,
   // oscillator trim outputs
   output logic       [7:0]  osc_trim,
   output logic       [7:0]  osc_option,
   // wake outputs
   output logic              frame_accept,
   output logic              wake_request,
   output logic              wake_config_error_flag,
   output logic       [5:0]  error_count_value
);
   import swd_pkg::*;

   // ********************************
   // register bus
   // ********************************
   swd_ctrl_t  ctrl;
   logic [7:0] bit_quanta_setting, ulim, llim;
   logic [5:0] sample_point_setting;
   logic [1:0] recovery_clock_select;
   logic [4:0] fd_dominant_filter;
   logic [15:0] pulse_count;
   logic       ack, wr, rd, idle_expire;
   logic [7:0] cur_q;

   // one wait cycle, then the answer
   always_ff @(posedge clk) begin
      if (!reset_n) ack <= 1'b0;
      else ack <= (avs_read | avs_write) & ~ack;
   end
   assign avs_waitrequest = ~ack;
   assign wr = avs_write & ack;
   assign rd = avs_read & ~ack;

   // read mux, unmapped reads zero
   always_ff @(posedge clk) begin
      if (!reset_n) avs_readdata <= 32'h0;
      else if (rd) begin
         case (avs_address)
            REG_CTRL: avs_readdata <= {25'h0, ctrl};
            REG_BITQ: avs_readdata <= {24'h0, bit_quanta_setting};
            REG_SPT:  avs_readdata <= {26'h0, sample_point_setting};
            REG_CSEL: avs_readdata <= {30'h0, recovery_clock_select};
            REG_ULIM: avs_readdata <= {24'h0, ulim};
            REG_LLIM: avs_readdata <= {24'h0, llim};
            REG_FILT: avs_readdata <= {27'h0, fd_dominant_filter};
            REG_CNTH: avs_readdata <= {24'h0, pulse_count[15:8]};
            REG_CNTL: avs_readdata <= {24'h0, pulse_count[7:0]};
            REG_TRIM: avs_readdata <= {24'h0, osc_trim};
            REG_OPT:  avs_readdata <= {24'h0, osc_option};
            REG_STAT: avs_readdata <= {8'h0, cur_q, 7'h0,
                                       wake_config_error_flag, 2'h0, error_count_value};
            default:  avs_readdata <= 32'h0;
         endcase
      end
   end

   // control word; idle timeout drops the freeze bit
   always_ff @(posedge clk) begin
      if (!reset_n) ctrl <= CTRL_RST;
      else if (wr && avs_address == REG_CTRL) ctrl <= swd_ctrl_t'(avs_writedata[6:0]);
      else if (idle_expire) ctrl.error_counter_freeze <= 1'b0;
   end

   // bit timing and recovery setup
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bit_quanta_setting    <= BITQ_RST;
         sample_point_setting  <= SPT_RST;
         recovery_clock_select <= CSEL_RST;
         ulim                  <= ULIM_RST;
         llim                  <= LLIM_RST;
         fd_dominant_filter    <= FILT_RST;
      end else if (wr) begin
         case (avs_address)
            REG_BITQ: bit_quanta_setting    <= avs_writedata[7:0];
            REG_SPT:  sample_point_setting  <= avs_writedata[5:0];
            REG_CSEL: recovery_clock_select <= avs_writedata[1:0];
            REG_ULIM: ulim                  <= avs_writedata[7:0];
            REG_LLIM: llim                  <= avs_writedata[7:0];
            REG_FILT: fd_dominant_filter    <= avs_writedata[4:0];
            default: ;
         endcase
      end
   end

   // ********************************
   // oscillator measure and trim
   // ********************************
   logic        txd_q, trim_open;
   logic [15:0] meas_cnt;
   assign trim_open = (ctrl.trim_unlock == UNLOCK) && ctrl.oscillator_measure_enable;

   // trim only while unlocked and measuring
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         osc_trim   <= TRIM_RST;
         osc_option <= OPT_RST;
      end else if (wr && trim_open) begin
         if (avs_address == REG_TRIM) osc_trim <= avs_writedata[7:0];
         if (avs_address == REG_OPT) osc_option <= avs_writedata[7:0];
      end
   end

   // time a low pulse, latch its length at release
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         txd_q       <= 1'b1;
         meas_cnt    <= 16'h0;
         pulse_count <= 16'h0;
      end else begin
         txd_q <= transmit_data_input;
         if (ctrl.oscillator_measure_enable) begin
            if (txd_q && !transmit_data_input) meas_cnt <= 16'h1;
            else if (!transmit_data_input && meas_cnt != 16'hFFFF)
               meas_cnt <= meas_cnt + 16'h1;
            if (!txd_q && transmit_data_input) pulse_count <= meas_cnt;
         end
      end
   end

   // ********************************
   // bit timing and clock recovery
   // ********************************
   swd_state_t state;
   logic       rxs, rx_q, fall, tq_tick, smp;
   logic [2:0] presc;
   logic [7:0] tq_cnt, spt_pos;
   logic [13:0] prod;

   function automatic logic [2:0] presc_lim(input logic [1:0] sel);
      presc_lim = 3'((4'h1 << sel) - 4'h1);
   endfunction : presc_lim

   assign rxs     = ctrl.wake_receiver_select ? rx_wake : rx_normal;
   assign fall    = rx_q && !rxs;
   assign tq_tick = presc == presc_lim(recovery_clock_select);
   assign prod    = 14'(cur_q) * 14'(sample_point_setting);
   assign spt_pos = prod[13:6];
   assign smp     = tq_tick && tq_cnt == spt_pos;

   // quantum prescaler and bit counter, resync on falling edge except in ST_SKIP
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_q   <= 1'b1;
         presc  <= 3'h0;
         tq_cnt <= 8'h0;
      end else begin
         rx_q <= rxs;
         if (fall && state != ST_SKIP) begin
            presc  <= 3'h0;
            tq_cnt <= 8'h0;
         end else begin
            presc <= tq_tick ? 3'h0 : presc + 3'h1;
            if (tq_tick) tq_cnt <= (tq_cnt >= cur_q - 8'h1) ? 8'h0 : tq_cnt + 8'h1;
         end
      end
   end

   // recovery: nudge quanta per bit by edge phase
   logic [7:0] next_q;
   always_comb begin
      next_q = cur_q;
      if (tq_cnt != cur_q - 8'h1) // in-phase edge falls on the last quantum
         next_q = (tq_cnt < {1'b0, cur_q[7:1]}) ? cur_q + 8'h1 : cur_q - 8'h1;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) cur_q <= BITQ_RST;
      else if (!ctrl.clock_recovery_enable) cur_q <= bit_quanta_setting;
      else if (fall && (state == ST_HEAD || state == ST_CLASSIC)) begin
         if (next_q >= ulim || next_q <= llim) cur_q <= bit_quanta_setting;
         else cur_q <= next_q;
      end
   end

   // ********************************
   // frame decoder
   // ********************************
   swd_evt_t   kind, evt;
   logic [4:0] bit_idx;
   logic [2:0] run;
   logic [3:0] rec;
   logic [4:0] dom_len;
   logic       last, dom_seen;

   // dominant filter for skipped data phase
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dom_len  <= 5'h0;
         dom_seen <= 1'b0;
      end else begin
         dom_len <= rxs ? 5'h0 : (dom_len == 5'h1F ? dom_len : dom_len + 5'h1);
         if (smp) dom_seen <= 1'b0;
         else if (!rxs && dom_len + 5'h1 >= fd_dominant_filter) dom_seen <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state   <= ST_IDLE;
         kind    <= '0;
         evt     <= '0;
         bit_idx <= 5'h0;
         run     <= 3'h0;
         rec     <= 4'h0;
         last    <= 1'b1;
      end else begin
         evt <= '0;
         case (state)
            ST_IDLE: begin
               if (fall && rec >= IDLE_BITS) begin
                  state   <= ST_HEAD;
                  bit_idx <= 5'h0; // sof counted at its own sample point
                  run     <= 3'h0;
                  last    <= 1'b0;
                  rec     <= 4'h0;
               end else if (smp) rec <= rxs ? (rec == 4'hF ? rec : rec + 4'h1) : 4'h0;
            end
            ST_HEAD, ST_CLASSIC: begin
               if (smp && run == STUFF_RUN) begin
                  if (rxs == last) begin
                     state <= ST_SKIP;
                     rec   <= 4'h0;
                     kind  <= (state == ST_CLASSIC && rxs) ? 3'b100 : 3'b001;
                  end else begin
                     run  <= 3'h1;
                     last <= rxs;
                  end
               end else if (smp) begin
                  run     <= (rxs == last) ? run + 3'h1 : 3'h1;
                  last    <= rxs;
                  bit_idx <= bit_idx + 5'h1;
                  if (state == ST_HEAD && bit_idx == EDL_IDX) begin
                     if (rxs) begin
                        state <= ST_SKIP;
                        rec   <= 4'h0;
                        kind  <= 3'b010;
                     end else state <= ST_CLASSIC;
                  end
               end
            end
            ST_SKIP: begin
               if (smp) begin
                  if (dom_seen || !rxs) rec <= 4'h0;
                  else if (rec + 4'h1 >= EOF_BITS) begin
                     state <= ST_IDLE;
                     evt   <= kind;
                     rec   <= EOF_BITS;
                  end else rec <= rec + 4'h1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ********************************
   // error counter, wake and idle timer
   // ********************************
   logic        inc, dec;
   logic [31:0] idle_cnt;
   assign inc = evt.err | (evt.fd & ~ctrl.fd_tolerance_enable);
   assign dec = evt.ok | (evt.fd & ctrl.fd_tolerance_enable);

   always_ff @(posedge clk) begin
      if (!reset_n) error_count_value <= 6'h0;
      else if (ctrl.fd_tolerance_enable && ctrl.error_counter_freeze)
         error_count_value <= 6'h0;
      else if (inc && error_count_value != ERR_OVF)
         error_count_value <= error_count_value + 6'h1;
      else if (dec && !inc && error_count_value != 6'h0 && error_count_value != ERR_OVF)
         error_count_value <= error_count_value - 6'h1;
   end

   // overflow wakes and flags; set wins over a clearing write
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wake_request           <= 1'b0;
         wake_config_error_flag <= 1'b0;
         frame_accept           <= 1'b0;
      end else begin
         wake_request <= inc && error_count_value == ERR_OVF - 6'h1 &&
                         !(ctrl.fd_tolerance_enable && ctrl.error_counter_freeze);
         frame_accept <= evt.ok;
         if (wake_request) wake_config_error_flag <= 1'b1;
         else if (wr && avs_address == REG_STAT && avs_writedata[STAT_FLAG])
            wake_config_error_flag <= 1'b0;
      end
   end

   // continuous recessive bus time
   always_ff @(posedge clk) begin
      if (!reset_n) idle_cnt <= 32'h0;
      else if (!rxs) idle_cnt <= 32'h0;
      else if (idle_cnt != 32'(IDLE_CYCLES)) idle_cnt <= idle_cnt + 32'h1;
   end
   assign idle_expire = rxs && idle_cnt == 32'(IDLE_CYCLES - 1);

   // ********************************
   // assertions
   // ********************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_TRIM_LOCK: assert property (wr && !trim_open |=> $stable(osc_trim))
      else $error("trim changed while locked");
   AST_TRIM_LOAD: assert property (wr && trim_open && avs_address == REG_TRIM
      |=> osc_trim == $past(avs_writedata[7:0]))
      else $error("trim write lost");
   AST_MEAS: assert property (ctrl.oscillator_measure_enable && !txd_q && transmit_data_input
      |=> pulse_count == $past(meas_cnt))
      else $error("pulse count not latched");
   AST_EDL_FD: assert property (state == ST_HEAD && smp && run != STUFF_RUN
      && bit_idx == EDL_IDX && rxs |=> state == ST_SKIP && kind.fd)
      else $error("fd frame not skipped");
   AST_EDL_CLASSIC: assert property (state == ST_HEAD && smp && run != STUFF_RUN
      && bit_idx == EDL_IDX && !rxs |=> state == ST_CLASSIC)
      else $error("classic frame not continued");
   AST_NO_FD_WAKE: assert property (evt.fd |=> !frame_accept)
      else $error("fd frame accepted");
   AST_FREEZE: assert property (ctrl.fd_tolerance_enable && ctrl.error_counter_freeze
      |=> error_count_value == 6'h0)
      else $error("frozen counter not zero");
   AST_FD_UP: assert property (evt.fd && !ctrl.fd_tolerance_enable
      && error_count_value < ERR_OVF
      |=> error_count_value == $past(error_count_value) + 6'h1)
      else $error("fd frame did not count up");
   AST_OK_DOWN: assert property (evt.ok && error_count_value != 6'h0
      && error_count_value != ERR_OVF && !ctrl.error_counter_freeze
      |=> error_count_value == $past(error_count_value) - 6'h1)
      else $error("good frame did not count down");
   AST_OVF: assert property (wake_request |-> error_count_value == ERR_OVF
      ##1 wake_config_error_flag)
      else $error("overflow not reported");
   AST_IDLE_CLR: assert property (idle_expire && !(wr && avs_address == REG_CTRL)
      |=> !ctrl.error_counter_freeze)
      else $error("freeze not cleared at timeout");
   AST_CDR_OFF: assert property (!ctrl.clock_recovery_enable
      |=> cur_q == $past(bit_quanta_setting))
      else $error("quanta not programmed value");
   AST_BUS: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus answer late");

   COV_FD_SKIP: cover property (evt.fd && ctrl.fd_tolerance_enable);
   COV_OK: cover property (frame_accept);
   COV_OVF: cover property (wake_request);
   COV_TRIM: cover property (wr && trim_open && avs_address == REG_OPT);
endmodule : swd_decoder

// [verification/swd_can_node.sv]
// swd_can_node: bus node model that feeds the decoder receiver lines
// assumes recessive-high receiver outputs and bit times counted in clk cycles
`timescale 1ns/100ps
module swd_can_node (
   // clock
   input  wire logic clk,
   // receiver lines
   output logic      rx_normal,
   output logic      rx_wake
);
   logic line;
   logic on_wake;
   // ******************************
   // line routing
   // ******************************
   // the receiver not in use idles recessive
   assign rx_normal = on_wake ? 1'b1 : line;
   assign rx_wake   = on_wake ? line : 1'b1;
   initial begin
      line    = 1'b1;
      on_wake = 1'b0;
   end
   // one level for n cycles, changed just after an edge
   task automatic hold(input logic b, input int n);
      line <= b;
      repeat (n) @(posedge clk);
   endtask : hold
   // kind 0 classic, 1 fd, 2 stuff fault in the header
   task automatic send(input int kind, input logic wk, input logic [31:0] rnd, input int bl);
      logic raw[$];
      logic last;
      int   run;
      on_wake <= wk;
      raw.push_back(1'b0);
      for (int i = 0; i < 13; i++) raw.push_back((kind == 2) ? 1'b0 : rnd[i]);
      raw.push_back(kind == 1);
      if (kind == 0) begin
         for (int i = 13; i < 21; i++) raw.push_back(rnd[i]);
      end
      last = 1'b1;
      run  = 0;
      // stuffing after five equal bits, left out on purpose for kind 2
      foreach (raw[i]) begin
         if (kind != 2 && run == 5) begin
            hold(!last, bl);
            last = !last;
            run  = 1;
         end
         hold(raw[i], bl);
         run  = (raw[i] == last) ? run + 1 : 1;
         last = raw[i];
      end
      // fast data phase: short glitches, then an unstuffed dominant run
      if (kind == 1) begin
         for (int i = 0; i < 16; i++) hold(rnd[i], 2);
         hold(1'b0, 6 * bl);
      end
      hold(1'b1, 16 * bl);
   endtask : send
endmodule : swd_can_node

// [verification/swd_decoder_bench.sv]
// swd_decoder_bench: self-checking bench for the selective-wake decoder
// assumes swd_pkg, swd_decoder and swd_can_node are compiled first
`timescale 1ns/100ps
module swd_decoder_bench;
   import swd_pkg::*;
   localparam int IDLE = 200;
   logic        clk;
   logic        reset_n;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        rx_normal;
   logic        rx_wake;
   logic        transmit_data_input;
   logic [7:0]  osc_trim;
   logic [7:0]  osc_option;
   logic        frame_accept;
   logic        wake_request;
   logic        wake_config_error_flag;
   logic [5:0]  error_count_value;
   logic [31:0] seed = 32'h40E4;
   logic [31:0] r;
   logic [63:0] note;
   logic [63:0] rd_q[$];
   logic        acc_q[$];
   logic        wk_q[$];
   logic [31:0] rst_tab[13];
   int          n_errors = 0;
   int          compares = 0;
   int          bitlen = 10;
   int          n;
   // ******************************
   // design and bus node
   // ******************************
   swd_decoder #(.IDLE_CYCLES(IDLE)) u_dut (.clk, .reset_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_normal, .rx_wake,
      .transmit_data_input, .osc_trim, .osc_option, .frame_accept, .wake_request,
      .wake_config_error_flag, .error_count_value);
   swd_can_node u_node (.clk, .rx_normal, .rx_wake);
   always #10 clk = ~clk;
   // ******************************
   // helpers
   // ******************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic give_verdict();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected read at %0t: %h not %h", $time, got, exp);
      end
   endtask : cmp_rd
   task automatic cmp_ev(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected event at %0t: %s", $time, what);
      end
   endtask : cmp_ev
   task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected port value at %0t: %h not %h", $time, got, exp);
      end
   endtask : cmp_port
   // avalon transfer held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m);
      rd_q.push_back({m, exp});
      bus(1'b0, a, 32'h0);
   endtask : rd
   // one frame, then the accept note must have been used up
   task automatic frame(input int kind, input logic wk, input logic acc);
      if (acc) acc_q.push_back(1'b1);
      u_node.send(kind, wk, xs(), bitlen);
      cmp_ev(acc_q.size() == 0, 1'b1, "accept missing");
   endtask : frame
   task automatic step(input int kind, input logic wk, input logic acc, input logic [5:0] c);
      frame(kind, wk, acc);
      cmp_port(32'(error_count_value), 32'(c));
   endtask : step
   // ******************************
   // result watcher
   // ******************************
   // each result takes the oldest note of its kind
   always @(posedge clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         note = (rd_q.size() > 0) ? rd_q.pop_front() : 64'hFFFFFFFF_FFFFFFFF;
         cmp_rd(avs_readdata & note[63:32], note[31:0]);
      end
      if (frame_accept === 1'b1) begin
         cmp_ev(acc_q.size() > 0, 1'b1, "accept not expected");
         if (acc_q.size() > 0) acc_q.delete(0);
      end
      if (wake_request === 1'b1) begin
         cmp_ev(wk_q.size() > 0, 1'b1, "wake not expected");
         if (wk_q.size() > 0) wk_q.delete(0);
      end
   end
   // watchdog
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      $display("unexpected timeout at %0t", $time);
      give_verdict();
   end
   // ******************************
   // main sequence
   // ******************************
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      transmit_data_input = 1'b1;
      rst_tab = '{32'(CTRL_RST), 32'(BITQ_RST), 32'(SPT_RST), 32'(CSEL_RST), 32'(ULIM_RST),
         32'(LLIM_RST), 32'(FILT_RST), 32'h0, 32'h0, 32'(TRIM_RST), 32'(OPT_RST),
         {8'h00, BITQ_RST, 16'h0000}, 32'h0};
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      wr(6'h3C, xs());
      for (int i = 0; i < 13; i++) rd((i == 12) ? 6'h3C : 6'(i * 4), rst_tab[i], 32'hFFFFFFFF);
      r = xs();
      wr(REG_TRIM, r);
      rd(REG_TRIM, 32'(TRIM_RST), 32'hFF);
      wr(REG_CTRL, 32'h61);
      wr(REG_TRIM, r);
      wr(REG_OPT, r >> 8);
      rd(REG_TRIM, {24'h0, r[7:0]}, 32'hFF);
      cmp_port(32'(osc_option), {24'h0, r[15:8]});
      wr(REG_CTRL, 32'h60);
      wr(REG_TRIM, ~r);
      wr(REG_CTRL, 32'h01);
      wr(REG_TRIM, ~r);
      cmp_port(32'(osc_trim), {24'h0, r[7:0]});
      // calibration pulses of random length
      for (int k = 0; k < 2; k++) begin
         n = 20 + int'(xs() % 400);
         transmit_data_input <= 1'b0;
         repeat (n) @(posedge clk);
         transmit_data_input <= 1'b1;
         repeat (4) @(posedge clk);
         rd(REG_CNTH, 32'(n[15:8]), 32'hFF);
         rd(REG_CNTL, 32'(n[7:0]), 32'hFF);
      end
      wr(REG_CTRL, 32'h00);
      step(1, 1'b0, 1'b0, 6'd1);
      step(2, 1'b0, 1'b0, 6'd2);
      step(0, 1'b0, 1'b1, 6'd1);
      step(2, 1'b0, 1'b0, 6'd2);
      wr(REG_CTRL, 32'h04);
      step(2, 1'b0, 1'b0, 6'd3);
      wr(REG_FILT, 32'(FILT_RST));
      wr(REG_CTRL, 32'h02);
      step(1, 1'b0, 1'b0, 6'd2);
      step(2, 1'b0, 1'b0, 6'd3);
      step(1, 1'b0, 1'b0, 6'd2);
      step(0, 1'b0, 1'b1, 6'd1);
      wr(REG_CTRL, 32'h12);
      step(0, 1'b1, 1'b1, 6'd0);
      step(0, 1'b0, 1'b0, 6'd0);
      wr(REG_CTRL, 32'h00);
      step(2, 1'b0, 1'b0, 6'd1);
      wr(REG_CTRL, 32'h06);
      rd(REG_STAT, 32'h0, 32'h3F);
      step(2, 1'b0, 1'b0, 6'd0);
      repeat (IDLE + 20) @(posedge clk);
      rd(REG_CTRL, 32'h02, 32'h7F);
      // overflow after 32 faulty frames
      wr(REG_CTRL, 32'h00);
      wk_q.push_back(1'b1);
      repeat (32) frame(2, 1'b0, 1'b0);
      rd(REG_STAT, 32'h120, 32'h13F);
      cmp_ev(wk_q.size() == 0, 1'b1, "wake missing");
      cmp_port(32'(wake_config_error_flag), 32'h1);
      wr(REG_STAT, 32'h100);
      rd(REG_STAT, 32'h20, 32'h13F);
      // recovery setup in the recommended order
      wr(REG_CSEL, 32'h0);
      wr(REG_BITQ, 32'h0C);
      wr(REG_ULIM, 32'h0D);
      wr(REG_LLIM, 32'h0B);
      wr(REG_SPT, 32'(SPT_RST));
      wr(REG_CTRL, 32'h08);
      rd(REG_STAT, 32'h000C0000, 32'h00FF0000);
      bitlen = 12;
      frame(0, 1'b0, 1'b1);
      rd(REG_STAT, 32'h000C0000, 32'h00FF0000);
      bitlen = 13;
      frame(0, 1'b0, 1'b1);
      rd(REG_STAT, 32'h000C0000, 32'h00FF0000);
      give_verdict();
   end
endmodule : swd_decoder_bench
